// >>> rtl/plc_link_cap_regs.sv
// Module: per-port link capabilities register with AXI4-Lite access
`default_nettype none
module plc_link_cap_regs #(
  parameter int unsigned MAX_LANES = 32
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  // AXI4-Lite write address and data
  input  wire logic [plc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [plc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  // Port straps
  input  wire logic [5:0]                phys_lanes_i,
  input  wire logic                      common_refclk_i,
  input  wire logic                      downstream_port_i,
  // Training values
  output logic [5:0]                     train_width_o,
  output logic [3:0]                     train_speed_o
);

  if (!(MAX_LANES inside {1, 2, 4, 8, 12, 16, 32}))
  begin : g_bad_lanes
    $error("MAX_LANES must be a legal link width");
  end

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN  = 2'b10
  } plc_state_e;

  // Register state
  plc_state_e                 state, next_state;
  logic [3:0]                 speed, next_speed;
  logic [5:0]                 width, next_width;
  logic [2:0]                 l1_exit, next_l1_exit;
  logic                       refclk_removal_capable, next_cpm;
  logic                       surprise_down_report_capable, next_surprise_down_report_capable;
  logic                       unlock, next_unlock;

  // Bus state
  logic                       aw_held, next_aw_held;
  logic [plc_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic                       w_held, next_w_held;
  logic [31:0]                w_data, next_w_data;
  logic [3:0]                 w_strb, next_w_strb;
  logic                       bvalid, next_bvalid;
  logic [1:0]                 bresp, next_bresp;
  logic                       rvalid, next_rvalid;
  logic [31:0]                rdata, next_rdata;
  logic [1:0]                 rresp, next_rresp;

  logic                       wr_do;
  logic [11:0]                wr_word;
  logic [11:0]                rd_word;
  logic [31:0]                wmask;
  plc_pkg::plc_lcap_s         cap_word;
  plc_pkg::plc_lcap_s         cap_new;
  plc_pkg::plc_train_s        train;

  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o  = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;
  assign train_width_o   = train.width;
  assign train_speed_o   = train.speed;

  // Write fires once address and data are both held, in whichever order they came
  assign wr_do   = aw_held && w_held && !bvalid;
  assign wr_word = {aw_addr[11:2], 2'b00};
  assign rd_word = {s_axi_araddr_i[11:2], 2'b00};

  always_comb
  begin
    cap_word          = '0;
    cap_word.speed    = speed;
    cap_word.width    = width;
    cap_word.aspm     = plc_pkg::ASPM_L0S_L1;
    cap_word.l0s_exit = common_refclk_i ? plc_pkg::L0S_COMMON : plc_pkg::L0S_SEPARATE;
    cap_word.l1_exit  = l1_exit;
    cap_word.refclk_removal_capable      = refclk_removal_capable;
    cap_word.surprise_down_report_capable    = surprise_down_report_capable;
    for (int i = 0; i < 4; i++)
    begin
      wmask[8*i +: 8] = {8{w_strb[i]}};
    end
    cap_new = plc_pkg::plc_lcap_s'((cap_word & ~wmask) | (w_data & wmask));
  end

  // Register next state
  always_comb
  begin
    next_state   = state;
    next_speed   = speed;
    next_width   = width;
    next_l1_exit = l1_exit;
    next_cpm     = refclk_removal_capable;
    next_surprise_down_report_capable   = surprise_down_report_capable;
    next_unlock  = unlock;
    unique case (state)
      ST_INIT:
      begin
        // Lane and port-type straps are caught on the first clock after reset release; common_refclk_i is used live
        next_width = phys_lanes_i;
        next_surprise_down_report_capable = downstream_port_i ? plc_pkg::SURPRISE_DOWN_REPORT_CAPABLE_DOWN : plc_pkg::SURPRISE_DOWN_REPORT_CAPABLE_UP;
        next_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (wr_do && wr_word == plc_pkg::LCAP_OFFSET && unlock)
        begin
          next_speed   = cap_new.speed;
          next_width   = cap_new.width;
          next_l1_exit = cap_new.l1_exit;
          next_cpm     = cap_new.refclk_removal_capable;
          next_surprise_down_report_capable   = cap_new.surprise_down_report_capable;
        end
        if (wr_do && wr_word == plc_pkg::UNLOCK_OFFSET && w_strb[0])
        begin
          next_unlock = w_data[0];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state   <= ST_INIT;
      speed   <= plc_pkg::SPEED_RST;
      width   <= plc_pkg::WIDTH_RST;
      l1_exit <= plc_pkg::L1_RST;
      refclk_removal_capable     <= plc_pkg::CPM_RST;
      surprise_down_report_capable   <= plc_pkg::SURPRISE_DOWN_REPORT_CAPABLE_UP;
      unlock  <= plc_pkg::UNLOCK_RST;
    end
    else
    begin
      state   <= next_state;
      speed   <= next_speed;
      width   <= next_width;
      l1_exit <= next_l1_exit;
      refclk_removal_capable     <= next_cpm;
      surprise_down_report_capable   <= next_surprise_down_report_capable;
      unlock  <= next_unlock;
    end
  end

  // Bus next state
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (wr_do)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      // Writes to read-only bits and locked fields are dropped silently
      next_bresp   = (wr_word == plc_pkg::LCAP_OFFSET || wr_word == plc_pkg::UNLOCK_OFFSET ||
                      wr_word == plc_pkg::STATUS_OFFSET) ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready_i)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rresp  = plc_pkg::RESP_OKAY;
      unique case (rd_word)
        plc_pkg::LCAP_OFFSET:   next_rdata = cap_word;
        plc_pkg::UNLOCK_OFFSET: next_rdata = {31'h0, unlock};
        plc_pkg::STATUS_OFFSET: next_rdata = {22'h0, train.speed, train.width};
        default:
        begin
          next_rdata = '0;
          next_rresp = plc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && s_axi_rready_i)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= plc_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= plc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  plc_width_resolve #(
    .MAX_LANES (MAX_LANES)
  ) i_plc_width_resolve (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .speed_i   (speed),
    .width_i   (width),
    .train_o   (train)
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_lcap_read;
    s_axi_arvalid_i && s_axi_arready_o && rd_word == plc_pkg::LCAP_OFFSET;
  endsequence

  sequence s_lcap_write_unlocked;
    wr_do && wr_word == plc_pkg::LCAP_OFFSET && unlock && w_strb[1:0] == 2'h3 && state == ST_RUN;
  endsequence

  property p_speed_reset;
    state == ST_INIT |-> speed == plc_pkg::SPEED_RST;
  endproperty
  a_speed_reset: assert property (p_speed_reset) else $error("speed field not 0x1 at reset");
  property p_width_strap;
    state == ST_RUN && $past(state) == ST_INIT |-> width == $past(phys_lanes_i);
  endproperty
  a_width_strap: assert property (p_width_strap) else $error("width not loaded from lanes");
  property p_narrow_write;
    logic [5:0] v;
    (s_lcap_write_unlocked, v = w_data[9:4]) ##1 (v inside {6'h01, 6'h02, 6'h04, 6'h08}) ##1 1'b1
      |-> train_width_o == v;
  endproperty
  a_narrow_write: assert property (p_narrow_write) else $error("written width not used");
  property p_aspm_read;
    s_lcap_read |=> s_axi_rdata_o[11:10] == plc_pkg::ASPM_L0S_L1;
  endproperty
  a_aspm_read: assert property (p_aspm_read) else $error("power support field not 0x3");
  property p_l0s_separate;
    s_lcap_read and !common_refclk_i |=> s_axi_rdata_o[14:12] == plc_pkg::L0S_SEPARATE;
  endproperty
  a_l0s_separate: assert property (p_l0s_separate) else $error("L0s latency not 0x5");
  property p_l0s_common;
    s_lcap_read and common_refclk_i |=> s_axi_rdata_o[14:12] == plc_pkg::L0S_COMMON;
  endproperty
  a_l0s_common: assert property (p_l0s_common) else $error("L0s latency not 0x3");
  property p_l1_reset;
    state == ST_INIT |-> l1_exit == plc_pkg::L1_RST;
  endproperty
  a_l1_reset: assert property (p_l1_reset) else $error("L1 latency not 0x2 at reset");
  property p_cpm_reset;
    state == ST_INIT |-> refclk_removal_capable == plc_pkg::CPM_RST;
  endproperty
  a_cpm_reset: assert property (p_cpm_reset) else $error("clock removal bit set at reset");
  property p_surprise_down_report_capable_strap;
    state == ST_RUN && $past(state) == ST_INIT |-> surprise_down_report_capable == $past(downstream_port_i);
  endproperty
  a_surprise_down_report_capable_strap: assert property (p_surprise_down_report_capable_strap) else $error("surprise-down bit wrong for port");
  property p_locked;
    !unlock && state == ST_RUN |=> $stable(width) && $stable(speed) && $stable(l1_exit) && $stable(surprise_down_report_capable) && $stable(refclk_removal_capable);
  endproperty
  a_locked: assert property (p_locked) else $error("locked field changed");

endmodule // plc_link_cap_regs
`default_nettype wire

// >>> rtl/plc_pkg.sv
// Package: offsets, field layout and reset values of the link capabilities register bank
`default_nettype none
package plc_pkg;

  // Register byte addresses
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] LCAP_OFFSET     = 12'h04c;
  localparam logic [11:0] UNLOCK_OFFSET   = 12'h100;
  localparam logic [11:0] STATUS_OFFSET   = 12'h104;

  // Field encodings and reset values
  localparam logic [3:0]  SPEED_GEN1      = 4'h1;
  localparam logic [3:0]  SPEED_GEN2      = 4'h2;
  localparam logic [3:0]  SPEED_RST       = 4'h1;
  localparam logic [5:0]  WIDTH_X1        = 6'h01;
  localparam logic [5:0]  WIDTH_RST       = 6'h01;
  localparam logic [1:0]  ASPM_L0S_L1     = 2'h3;
  localparam logic [2:0]  L0S_SEPARATE    = 3'h5;
  localparam logic [2:0]  L0S_COMMON      = 3'h3;
  localparam logic [2:0]  L1_RST          = 3'h2;
  localparam logic        CPM_RST         = 1'b0;
  localparam logic        SURPRISE_DOWN_REPORT_CAPABLE_DOWN      = 1'b1;
  localparam logic        SURPRISE_DOWN_REPORT_CAPABLE_UP        = 1'b0;
  localparam logic        UNLOCK_RST      = 1'b0;

  // L1 to L0 return time, ns, behind the L1 exit latency code
  localparam int unsigned L1_EXIT_NS      = 2300;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Register image, bit 0 is speed bit 0
  typedef struct packed {
    logic [11:0] rsvd;
    logic        surprise_down_report_capable;
    logic        refclk_removal_capable;
    logic [2:0]  l1_exit;
    logic [2:0]  l0s_exit;
    logic [1:0]  aspm;
    logic [5:0]  width;
    logic [3:0]  speed;
  } plc_lcap_s;

  // Width and speed the port actually trains with
  typedef struct packed {
    logic [3:0]  speed;
    logic [5:0]  width;
  } plc_train_s;

endpackage
`default_nettype wire

// >>> rtl/plc_width_resolve.sv
// Module: turns written speed and width codes into the values the port trains with
`default_nettype none
module plc_width_resolve #(
  parameter int unsigned MAX_LANES = 32
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Register fields
  input  wire logic [3:0]        speed_i,
  input  wire logic [5:0]        width_i,
  // Training values
  output var plc_pkg::plc_train_s train_o
);

  plc_pkg::plc_train_s next_train;
  logic                width_ok;

  always_comb
  begin
    unique case (width_i)
      6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: width_ok = 1'b1;
      default: width_ok = 1'b0;
    endcase
    // Codes above MAX_LANES cannot train either
    if (32'(width_i) > MAX_LANES)
    begin
      width_ok = 1'b0;
    end
    next_train.width = width_ok ? width_i : plc_pkg::WIDTH_X1;
    // Reserved speed codes fall back to the lowest rate
    next_train.speed = (speed_i == plc_pkg::SPEED_GEN2) ? plc_pkg::SPEED_GEN2 : plc_pkg::SPEED_GEN1;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      train_o <= '{speed: plc_pkg::SPEED_RST, width: plc_pkg::WIDTH_RST};
    end
    else
    begin
      train_o <= next_train;
    end
  end

  property p_invalid_x1;
    @(posedge clk_i) disable iff (reset_i)
    !(width_i inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20}) ##1 $stable(width_i)
      |-> train_o.width == plc_pkg::WIDTH_X1;
  endproperty
  a_invalid_x1: assert property (p_invalid_x1) else $error("reserved width not trained as x1");

endmodule // plc_width_resolve
`default_nettype wire

// >>> testbench/plc_link_cap_regs_bench.sv
// Bench: self-checking bench for the link capabilities register bank
`default_nettype none
module plc_link_cap_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] UNMAPPED = 12'h200;

  logic        clk_i;
  logic        reset_i;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [5:0]  phys_lanes;
  logic        common_refclk;
  logic        downstream;
  logic [5:0]  train_width;
  logic [3:0]  train_speed;
  int          bad_count;
  int          cmp_count;
  // Bench copy of the lockable fields
  logic [3:0]  m_speed;
  logic [5:0]  m_width;
  logic [2:0]  m_l1;
  logic        m_cpm;
  logic        m_sd;

  plc_link_cap_regs #(.MAX_LANES(32)) i_plc_link_cap_regs (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .s_axi_awaddr_i    (awaddr),
    .s_axi_awvalid_i   (awvalid),
    .s_axi_awready_o   (awready),
    .s_axi_wdata_i     (wdata),
    .s_axi_wstrb_i     (wstrb),
    .s_axi_wvalid_i    (wvalid),
    .s_axi_wready_o    (wready),
    .s_axi_bresp_o     (bresp),
    .s_axi_bvalid_o    (bvalid),
    .s_axi_bready_i    (bready),
    .s_axi_araddr_i    (araddr),
    .s_axi_arvalid_i   (arvalid),
    .s_axi_arready_o   (arready),
    .s_axi_rdata_o     (rdata),
    .s_axi_rresp_o     (rresp),
    .s_axi_rvalid_o    (rvalid),
    .s_axi_rready_i    (rready),
    .phys_lanes_i      (phys_lanes),
    .common_refclk_i   (common_refclk),
    .downstream_port_i (downstream),
    .train_width_o     (train_width),
    .train_speed_o     (train_speed)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Ends 1 ns after the last edge so results are settled
  task automatic axi_write(input logic [11:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    @(posedge clk_i);
    awaddr  <= addr;
    awvalid <= 1'b1;
    wdata   <= data;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    #1;
    while (awvalid || wvalid)
    begin
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      @(posedge clk_i);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      #1;
    end
    b_hit = 1'b0;
    while (!b_hit)
    begin
      b_hit = bvalid;
      resp  = bresp;
      @(posedge clk_i);
      if (b_hit) bready <= 1'b0;
      #1;
    end
  endtask

  task automatic axi_read(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
    logic hit;
    @(posedge clk_i);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    #1;
    while (arvalid)
    begin
      hit = arready;
      @(posedge clk_i);
      if (hit) arvalid <= 1'b0;
      #1;
    end
    hit = 1'b0;
    while (!hit)
    begin
      hit  = rvalid;
      data = rdata;
      resp = rresp;
      @(posedge clk_i);
      if (hit) rready <= 1'b0;
      #1;
    end
  endtask

  task automatic do_reset(input logic [5:0] lanes, input logic cref, input logic down);
    @(posedge clk_i);
    reset_i       <= 1'b1;
    phys_lanes    <= lanes;
    common_refclk <= cref;
    downstream    <= down;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    m_speed = 4'h1;
    m_width = lanes;
    m_l1    = 3'h2;
    m_cpm   = 1'b0;
    m_sd    = down;
  endtask

  function automatic logic [31:0] exp_lcap();
    plc_pkg::plc_lcap_s v;
    v          = '0;
    v.speed    = m_speed;
    v.width    = m_width;
    v.aspm     = 2'h3;
    v.l0s_exit = common_refclk ? 3'h3 : 3'h5;
    v.l1_exit  = m_l1;
    v.refclk_removal_capable      = m_cpm;
    v.surprise_down_report_capable    = m_sd;
    return 32'(v);
  endfunction

  function automatic logic [5:0] exp_train_w(input logic [5:0] w);
    if (w == 6'h01 || w == 6'h02 || w == 6'h04 || w == 6'h08 || w == 6'h0c || w == 6'h10 || w == 6'h20)
      return w;
    return 6'h01;
  endfunction

  // Whole register and training outputs against the bench copy
  task automatic check_lcap(input string tname);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(plc_pkg::LCAP_OFFSET, d, r);
    check({tname, " read"}, exp_lcap(), d);
    check({tname, " rresp"}, 32'(2'h0), 32'(r));
    check({tname, " width"}, 32'(exp_train_w(m_width)), 32'(train_width));
    check({tname, " speed"}, 32'((m_speed == 4'h2) ? 4'h2 : 4'h1), 32'(train_speed));
    axi_read(plc_pkg::STATUS_OFFSET, d, r);
    check({tname, " status"}, 32'(exp_train_w(m_width)), 32'(d[5:0]));
    check({tname, " status speed"}, 32'((m_speed == 4'h2) ? 4'h2 : 4'h1), 32'(d[9:6]));
  endtask

  logic [5:0]  corner_w [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h3f};
  logic [3:0]  corner_s [4] = '{4'h1, 4'h2, 4'h0, 4'hf};

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    bad_count = 0;
    cmp_count = 0;
    reset_i = 1'b1; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = 4'hf; wvalid = 1'b0;
    bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
    phys_lanes = 6'h10; common_refclk = 1'b0; downstream = 1'b1;
    void'($urandom(32'h0b92));
    do_reset(6'h10, 1'b0, 1'b1);
    check_lcap("reset downstream x16");
    $display("test reset values done");

    // Locked: write answers OKAY but changes nothing
    axi_write(plc_pkg::LCAP_OFFSET, 32'h000f_ff22, r);
    check("locked bresp", 32'(2'h0), 32'(r));
    check_lcap("locked write");
    $display("test locked write done");

    axi_write(plc_pkg::UNLOCK_OFFSET, 32'h0000_0001, r);
    for (int i = 0; i < 20; i++)
    begin
      d = $urandom;
      if (i < 8)
      begin
        d[9:4] = corner_w[i];
        d[3:0] = corner_s[i % 4];
      end
      else
        d[9:4] = 6'($urandom_range(16, 0));
      common_refclk <= d[31];
      axi_write(plc_pkg::LCAP_OFFSET, d, r);
      m_speed = d[3:0];
      m_width = d[9:4];
      m_l1    = d[17:15];
      m_cpm   = d[18];
      m_sd    = d[19];
      check_lcap("unlocked write");
    end
    // Low byte only: speed and the low four width bits
    d = $urandom;
    wstrb <= 4'h1;
    axi_write(plc_pkg::LCAP_OFFSET, d, r);
    wstrb <= 4'hf;
    m_speed      = d[3:0];
    m_width[3:0] = d[7:4];
    check_lcap("byte strobe write");
    $display("test width and speed override done");

    axi_read(UNMAPPED, d, r);
    check("unmapped rresp", 32'(2'h2), 32'(r));
    check("unmapped rdata", 32'h0, d);
    axi_write(UNMAPPED, 32'hffff_ffff, r);
    check("unmapped bresp", 32'(2'h2), 32'(r));
    $display("test unmapped access done");

    do_reset(6'h04, 1'b1, 1'b0);
    check_lcap("reset upstream x4");
    axi_write(plc_pkg::LCAP_OFFSET, 32'h0000_0012, r);
    check_lcap("relocked after reset");
    $display("test second reset done");
    results();
  end

  // Some 76 accesses of under 10 cycles each; far above that means a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    results();
  end

endmodule // plc_link_cap_regs_bench
`default_nettype wire
